// ### bench/icc_cpu_model.sv
// Behavioural CPU core that hands the interrupts presented to it to the block.
// Assumes one clock; the bench calls present to hand over one interrupt.
`timescale 1ns/10ps
module icc_cpu_model import icc_pkg::*; (
  input wire logic aclk,
  output icc_pres_t pres_in
);
  // Nothing is presented at time zero.
  initial pres_in = '0;
  // One-cycle presentation; afterwards the idle fields show inverted stale values.
  task automatic present(input logic [2:0] p, input logic [5:0] v);
    @(posedge aclk);
    pres_in <= {1'b1, p, v};
    @(posedge aclk);
    pres_in <= {1'b0, ~p, ~v};
  endtask
endmodule // icc_cpu_model

// ### bench/icc_top_asserts.sv
// Concurrent checks on the ports of the interrupt configuration block.
// Assumes it is bound to icc_top; every check uses aclk and aresetn.
`timescale 1ns/10ps
module icc_top_asserts import icc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [4:0] ext_irq_in,
  input wire icc_pres_t pres_in,
  input wire logic multi_dispatch_select,
  input wire logic prox_timer_running,
  input wire logic ext_irq_event
);
  // All checks share the one clock and are off during reset.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_multi_dispatch_select_by_write: assert property ($changed(multi_dispatch_select) |-> $rose(s_axi_bvalid))
    else $error("mode output moved without a write");
  a_ctl_unused_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] == 4'h0
    |=> s_axi_rvalid && (s_axi_rdata & 32'hFFFFE8E0) == 32'h0) else $error("control spare bits set");
  a_stat_unused_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] == 4'h1
    |=> s_axi_rvalid && (s_axi_rdata & 32'hFFFFF8C0) == 32'h0) else $error("status spare bits set");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40
    |=> s_axi_rresp == ICC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_prio0_no_start: assert property (pres_in.valid && pres_in.prio == 3'h0 && !prox_timer_running
    |=> !prox_timer_running) else $error("priority zero started the timer");
  a_start_cause: assert property ($rose(prox_timer_running)
    |-> $past(pres_in.valid) && $past(pres_in.prio) != 3'h0) else $error("timer started alone");
  a_event_cause: assert property ($rose(ext_irq_event) |-> $past(ext_irq_in, 5) != ext_irq_in)
    else $error("pin event without a pin change");
endmodule // icc_top_asserts

// ### bench/irq_ctrl_config_status_tb_top.sv
// Top bench: AXI4-Lite tasks, the CPU partner, pin stimulus and checker bind.
// Assumes the package, icc_top, icc_cpu_model and the checker compile first.
`timescale 1ns/10ps
module irq_ctrl_config_status_tb_top import icc_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_v;
  logic [4:0] ext_irq_in = 5'h00;
  icc_pres_t pres_in;
  logic multi_dispatch_select, prox_timer_running, ext_irq_event, irq;
  int error_cnt = 0;
  int n_compared = 0;

  icc_top i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ext_irq_in(ext_irq_in),
    .pres_in(pres_in),
    .multi_dispatch_select(multi_dispatch_select),
    .prox_timer_running(prox_timer_running),
    .ext_irq_event(ext_irq_event),
    .irq(irq)
  );
  icc_cpu_model i_cpu (
    .aclk(aclk),
    .pres_in(pres_in)
  );

  // Clock of 25 ns period.
  always #12.5 aclk = ~aclk;

  // Compares one value and logs a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Writes one word; address and data go together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    {ta, tw, done} = 3'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      done = s_axi_bvalid;
      resp_v = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  // Reads one word and compares it with the expected value.
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic ta, done;
    {ta, done} = 2'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = ta | s_axi_arready;
      done = s_axi_rvalid;
      rd_v = s_axi_rdata;
      resp_v = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(rd_v, e);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hung run short after about 8000 cycles.
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence: registers, aliases, status, proximity timer, pins, unmapped.
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ICC_CTL_OFS, ICC_CTL_RST);
    rc(ICC_STAT_OFS, ICC_STAT_RST);
    rc(ICC_RELOAD_OFS, ICC_RELOAD_RST);
    wr(ICC_CTL_OFS, 32'hFFFFFFFF);
    rc(ICC_CTL_OFS, 32'h0000171F);
    chk(multi_dispatch_select, 1'b1);
    wr(ICC_CTL_OFS + 8'h04, 32'h00001001);
    rc(ICC_CTL_OFS, 32'h0000071E);
    chk(multi_dispatch_select, 1'b0);
    wr(ICC_CTL_OFS + 8'h0C, 32'h00000303);
    rc(ICC_CTL_OFS, 32'h0000041D);
    wr(ICC_CTL_OFS + 8'h08, 32'h00000002);
    rc(ICC_CTL_OFS, 32'h0000041F);
    wr(ICC_STAT_OFS, 32'hFFFFFFFF);
    rc(ICC_STAT_OFS, 32'h0000073F);
    i_cpu.present(3'h5, 6'h2A);
    rc(ICC_STAT_OFS, 32'h0000052A);
    wr(ICC_RELOAD_OFS, 32'h00000001);
    wr(ICC_RELOAD_OFS + 8'h08, 32'h000000A0);
    rc(ICC_RELOAD_OFS, 32'h000000A1);
    // Only the strobed byte of an invert write may toggle.
    s_axi_wstrb <= 4'h2;
    wr(ICC_RELOAD_OFS + 8'h0C, 32'hFFFFFFFF);
    rc(ICC_RELOAD_OFS, 32'h0000FFA1);
    s_axi_wstrb <= 4'hF;
    wr(ICC_RELOAD_OFS, 32'h00000001);
    wr(ICC_MASK_OFS, 32'h0000003F);
    // Each trigger level: one priority outside it, then for levels 1 to 7 the level itself.
    for (int n = 0; n < 8; n++) begin
      wr(ICC_CTL_OFS, 32'(n) << 8);
      i_cpu.present((n == 7) ? 3'h0 : 3'(n + 1), 6'h01);
      @(negedge aclk);
      chk(prox_timer_running, 1'b0);
      if (n > 0) begin
        i_cpu.present(3'(n), 6'h02);
        @(negedge aclk);
        chk(prox_timer_running, 1'b1);
        @(negedge aclk);
        chk(prox_timer_running, 1'b1);
        @(negedge aclk);
        chk(prox_timer_running, 1'b0);
      end
    end
    rc(ICC_FLAG_OFS, 32'h00000020);
    wr(ICC_FLAG_OFS, 32'h00000020);
    rc(ICC_FLAG_OFS, 32'h00000000);
    // A long count is stopped by a zero trigger level, without an expiry flag.
    wr(ICC_RELOAD_OFS, 32'h00000040);
    i_cpu.present(3'h1, 6'h03);
    @(negedge aclk);
    chk(prox_timer_running, 1'b1);
    wr(ICC_CTL_OFS, 32'h00000000);
    @(negedge aclk);
    chk(prox_timer_running, 1'b0);
    rc(ICC_FLAG_OFS, 32'h00000000);
    // Rising edges on inputs 0, 2 and 4, then falling edges on 1 and 3.
    wr(ICC_CTL_OFS, 32'h00000015);
    ext_irq_in <= 5'h1F;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(ext_irq_event, 1'b1);
    @(negedge aclk);
    chk(ext_irq_event, 1'b0);
    rc(ICC_FLAG_OFS, 32'h00000015);
    wr(ICC_FLAG_OFS, 32'h0000003F);
    ext_irq_in <= 5'h00;
    repeat (6) @(posedge aclk);
    rc(ICC_FLAG_OFS, 32'h0000000A);
    @(negedge aclk);
    chk(irq, 1'b1);
    wr(ICC_MASK_OFS, 32'h00000015);
    @(negedge aclk);
    chk(irq, 1'b0);
    rc(8'h40, 32'h00000000);
    chk(resp_v, ICC_RESP_SLVERR);
    wr(8'h38, 32'h00000001);
    chk(resp_v, ICC_RESP_SLVERR);
    report_and_stop();
  end
endmodule // irq_ctrl_config_status_tb_top

bind icc_top icc_top_asserts u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .ext_irq_in(ext_irq_in),
  .pres_in(pres_in),
  .multi_dispatch_select(multi_dispatch_select),
  .prox_timer_running(prox_timer_running),
  .ext_irq_event(ext_irq_event)
);

// ### hdl/icc_top.sv
// Interrupt controller configuration and status block with an AXI4-Lite slave.
// Assumes aclk at 40 MHz, synchronous active-low reset, and external pins
// that are asynchronous to aclk; the presentation input comes from aclk logic.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module icc_top import icc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] ext_irq_in,
  input wire icc_pres_t pres_in,
  output logic multi_dispatch_select,
  output logic prox_timer_running,
  output logic ext_irq_event,
  output logic irq
);

  // Byte strobes widened to a bit mask.
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Applies a plain, clear, set or invert alias write to a register.
  function automatic logic [31:0] alias_wr(input logic [31:0] old,
      input logic [31:0] d, input logic [1:0] kind, input logic [31:0] m);
    logic [31:0] v;
    v = old;
    case (kind)
      ICC_AL_PLAIN: v = (old & ~m) | (d & m);
      ICC_AL_CLR: v = old & ~(d & m);
      ICC_AL_SET: v = old | (d & m);
      ICC_AL_INV: v = old ^ (d & m);
      default: v = old;
    endcase
    alias_wr = v;
  endfunction

  // True when the address falls in the given aliased group.
  function automatic logic in_group(input logic [7:0] a, input logic [7:0] g);
    in_group = (a[7:4] == g[7:4]);
  endfunction

  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] ctl_r, ctl_nxt;
  logic [31:0] stat_r, stat_nxt;
  logic [31:0] reload_r, reload_nxt;
  logic [5:0] flag_r, flag_nxt;
  logic [5:0] mask_r, mask_nxt;
  logic [4:0] sync1_r, sync2_r, prev_r;
  logic [4:0] edge_hit;
  logic [31:0] count_r, count_nxt;
  icc_tstate_t tstate_r, tstate_nxt;
  logic run_r, run_nxt;
  logic irq_r, irq_nxt;
  logic ev_r, ev_nxt;
  logic do_wr;
  logic [31:0] wm;
  logic [2:0] trig;
  logic prox_start;
  logic prox_done;

  // Input pins pass two flip-flops; prev_r reads only the second one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      prev_r <= 5'h00;
    end else begin
      sync1_r <= ext_irq_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Edge of the selected polarity for each external input.
  always_comb begin
    for (int i = 0; i < ICC_NEXT; i++) begin
      edge_hit[i] = ctl_r[ICC_POL_LSB + i] ? (sync2_r[i] & ~prev_r[i])
                                           : (~sync2_r[i] & prev_r[i]);
    end
  end

  // Proximity trigger decision on each presented interrupt.
  always_comb begin
    trig = ctl_r[ICC_TRIG_LSB +: 3];
    prox_start = pres_in.valid && (trig != 3'h0)
                 && (pres_in.prio != 3'h0) && (pres_in.prio <= trig);
    prox_done = (tstate_r == ICC_T_RUN) && (count_r == 32'h00000000);
  end

  // Write channel acceptance, register update and write response.
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctl_nxt = ctl_r;
    stat_nxt = stat_r;
    reload_nxt = reload_r;
    mask_nxt = mask_r;
    if (s_axi_awvalid && awready_r) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    do_wr = aw_full_r && w_full_r && !bvalid_r;
    wm = strb_mask(w_strb_r);
    if (do_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = ICC_RESP_OKAY;
      if (in_group(aw_addr_r, ICC_CTL_OFS)) begin
        ctl_nxt = alias_wr(ctl_r, w_data_r, aw_addr_r[3:2], wm);
      end else if (in_group(aw_addr_r, ICC_STAT_OFS)) begin
        stat_nxt = alias_wr(stat_r, w_data_r, aw_addr_r[3:2], wm);
      end else if (in_group(aw_addr_r, ICC_RELOAD_OFS)) begin
        reload_nxt = alias_wr(reload_r, w_data_r, aw_addr_r[3:2], wm);
      end else if (aw_addr_r == ICC_MASK_OFS) begin
        mask_nxt = w_data_r[5:0] & wm[5:0];
      end else if (aw_addr_r != ICC_FLAG_OFS) begin
        bresp_nxt = ICC_RESP_SLVERR;
      end
    end
    // Unimplemented bits never store a one.
    ctl_nxt = ctl_nxt & ICC_CTL_MASK;
    // The latest presented interrupt overrides a software write.
    if (pres_in.valid) begin
      stat_nxt[ICC_PRIO_LSB +: 3] = pres_in.prio;
      stat_nxt[ICC_VEC_LSB +: 6] = pres_in.vec;
    end
    stat_nxt = stat_nxt & ICC_STAT_MASK;
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
  end

  // Sticky event flags: hardware sets win over a write-one-to-clear.
  always_comb begin
    flag_nxt = flag_r;
    if (do_wr && (aw_addr_r == ICC_FLAG_OFS)) begin
      flag_nxt = flag_r & ~(w_data_r[5:0] & wm[5:0]);
    end
    flag_nxt[ICC_NEXT-1:0] = flag_nxt[ICC_NEXT-1:0] | edge_hit;
    if (prox_done) begin
      flag_nxt[ICC_FLAG_PROX] = 1'b1;
    end
    irq_nxt = |(flag_nxt & mask_nxt);
    ev_nxt = |edge_hit;
  end

  // Proximity timer: loaded on a qualifying interrupt, counts down to zero.
  always_comb begin
    tstate_nxt = tstate_r;
    count_nxt = count_r;
    case (tstate_r)
      ICC_T_IDLE: begin
        count_nxt = count_r;
      end
      ICC_T_RUN: begin
        if (count_r == 32'h00000000) begin
          tstate_nxt = ICC_T_IDLE;
        end else begin
          count_nxt = count_r - 32'h00000001;
        end
      end
      default: begin
        tstate_nxt = ICC_T_IDLE;
      end
    endcase
    if (prox_start) begin
      tstate_nxt = ICC_T_RUN;
      count_nxt = reload_r;
    end
    if (ctl_r[ICC_TRIG_LSB +: 3] == 3'h0) begin
      tstate_nxt = ICC_T_IDLE;
    end
    // Running flag is registered so the output needs no decode after the flop.
    run_nxt = (tstate_nxt == ICC_T_RUN);
  end

  // Read channel: one read at a time, data one cycle after acceptance.
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = ICC_RESP_OKAY;
      rdata_nxt = 32'h00000000;
      if (in_group(s_axi_araddr, ICC_CTL_OFS)) begin
        rdata_nxt = ctl_r & ICC_CTL_MASK;
      end else if (in_group(s_axi_araddr, ICC_STAT_OFS)) begin
        rdata_nxt = stat_r & ICC_STAT_MASK;
      end else if (in_group(s_axi_araddr, ICC_RELOAD_OFS)) begin
        rdata_nxt = reload_r;
      end else if (s_axi_araddr == ICC_FLAG_OFS) begin
        rdata_nxt = {26'h0000000, flag_r};
      end else if (s_axi_araddr == ICC_MASK_OFS) begin
        rdata_nxt = {26'h0000000, mask_r};
      end else begin
        rresp_nxt = ICC_RESP_SLVERR;
      end
    end
  end

  // State registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= ICC_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= ICC_RESP_OKAY;
      ctl_r <= ICC_CTL_RST;
      stat_r <= ICC_STAT_RST;
      reload_r <= ICC_RELOAD_RST;
      flag_r <= ICC_FLAG_RST;
      mask_r <= ICC_FLAG_RST;
      count_r <= 32'h00000000;
      tstate_r <= ICC_T_IDLE;
      run_r <= 1'b0;
      irq_r <= 1'b0;
      ev_r <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctl_r <= ctl_nxt;
      stat_r <= stat_nxt;
      reload_r <= reload_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      count_r <= count_nxt;
      tstate_r <= tstate_nxt;
      run_r <= run_nxt;
      irq_r <= irq_nxt;
      ev_r <= ev_nxt;
    end
  end

  // Outputs come straight from flip-flops.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign multi_dispatch_select = ctl_r[ICC_MULTI_DISPATCH_SELECT_POS];
  assign prox_timer_running = run_r;
  assign ext_irq_event = ev_r;
  assign irq = irq_r;

endmodule // icc_top

// ### shared/icc_pkg.sv
// Constants, field layouts and carrier types of the interrupt configuration block.
// Assumes a 32-bit AXI4-Lite register bus and a single 40 MHz system clock.
package icc_pkg;
  // Register byte offsets; aliased registers take a 16-byte group.
  localparam logic [7:0] ICC_CTL_OFS = 8'h00;
  localparam logic [7:0] ICC_STAT_OFS = 8'h10;
  localparam logic [7:0] ICC_RELOAD_OFS = 8'h20;
  localparam logic [7:0] ICC_FLAG_OFS = 8'h30;
  localparam logic [7:0] ICC_MASK_OFS = 8'h34;
  // Alias selectors within a group, taken from address bits 3:2.
  localparam logic [1:0] ICC_AL_PLAIN = 2'h0;
  localparam logic [1:0] ICC_AL_CLR = 2'h1;
  localparam logic [1:0] ICC_AL_SET = 2'h2;
  localparam logic [1:0] ICC_AL_INV = 2'h3;
  // Control register fields.
  localparam int ICC_MULTI_DISPATCH_SELECT_POS = 12;
  localparam int ICC_TRIG_LSB = 8;
  localparam int ICC_POL_LSB = 0;
  localparam logic [31:0] ICC_CTL_MASK = 32'h0000171F;
  // Status register fields.
  localparam int ICC_PRIO_LSB = 8;
  localparam int ICC_VEC_LSB = 0;
  localparam logic [31:0] ICC_STAT_MASK = 32'h0000073F;
  // Event flags: five external inputs and proximity timer expiry.
  localparam int ICC_NEXT = 5;
  localparam int ICC_NFLAG = 6;
  localparam int ICC_FLAG_PROX = 5;
  // Values after reset.
  localparam logic [31:0] ICC_CTL_RST = 32'h00000000;
  localparam logic [31:0] ICC_STAT_RST = 32'h00000000;
  localparam logic [31:0] ICC_RELOAD_RST = 32'h00000000;
  localparam logic [5:0] ICC_FLAG_RST = 6'h00;
  // AXI responses.
  localparam logic [1:0] ICC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ICC_RESP_SLVERR = 2'h2;

  // Interrupt presented to the CPU core, one cycle wide when valid.
  typedef struct packed {
    logic valid;
    logic [2:0] prio;
    logic [5:0] vec;
  } icc_pres_t;

  // Proximity timer states.
  typedef enum logic [1:0] {
    ICC_T_IDLE = 2'b01,
    ICC_T_RUN = 2'b10
  } icc_tstate_t;
endpackage
